/* File: pkg/swcfg_pkg.sv */
// constants for the switch port configuration register set
package swcfg_pkg;
  localparam int unsigned num_ports = 8;
  localparam logic [4:0] own_port = 5'h00;
  localparam logic is_primary = 1'b1;
  localparam int unsigned num_pairs = 4;
  localparam int unsigned num_ctrs = 12;
  localparam logic [7:0] off_cmd = 8'h00;
  localparam logic [7:0] off_mask = 8'h04;
  localparam logic [7:0] off_info = 8'h08;
  localparam logic [7:0] off_ctr = 8'h0c;
  localparam logic [7:0] off_range = 8'h10;
  localparam logic [7:0] cap_id = 8'h08;
  localparam logic [7:0] cap_next = 8'h00;
  localparam logic [4:0] cap_type = 5'h08;
  localparam int unsigned cmd_abort_bit = 7;
  localparam int unsigned cmd_flood_bit = 8;
  localparam int unsigned cmd_fatal_bit = 9;
  localparam int unsigned cmd_nonfatal_bit = 10;
  localparam int unsigned info_decode_bit = 5;
  localparam int unsigned info_cold_bit = 6;
  localparam int unsigned info_hotswap_bit = 22;
  localparam int unsigned info_hide_bit = 23;
  localparam logic [4:0] default_port_reset = 5'h01;
  localparam logic [3:0] ctr_index_reset = 4'h0;
  localparam logic [5:0] range_index_reset = 6'h00;
  localparam logic [31:0] mask_reset = 32'h0000_00ff;
  localparam logic [31:0] range_keep_mask = 32'hff00_0000;
  localparam logic [31:0] ctr_full = 32'hffff_ffff;
endpackage

/* File: rtl/range_store.sv */
// storage for the indexed base/limit range words
`timescale 1ns/100ps
module range_store (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] addr,
  input wire logic wr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  import swcfg_pkg::*;
  logic [31:0] mem [0:4*num_pairs-1];
  logic [31:0] wmask;
  logic implemented;
  assign implemented = addr[5:2] < 4'(num_pairs);
  // base low keeps bit 0 as enable; limit low has no enable bit
  assign wmask = addr[0] ? 32'hffff_ffff
      : addr[1] ? range_keep_mask : (range_keep_mask | 32'h1);
  genvar i;
  generate
    for (i = 0; i < 4 * num_pairs; i++) begin : g_word
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem[i] <= 32'h0;
        end else if (wr && implemented && addr == 6'(i)) begin
          mem[i] <= wdata & wmask;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (!implemented) begin
      rdata <= addr[1] ? 32'h0 : 32'hffff_ffff;
    end else begin
      rdata <= mem[addr[3:0]];
    end
  end
endmodule

/* File: rtl/switch_port_config_regs.sv */
// switch port configuration registers, counters and range decode
// Behaviour
// - nonfatal interrupt from abort flag only when its enable is set
// - capability type field reads hardwired constant 01000b
// - mask bit n lets port n receive; absent ports 0, own port 1
// - partition mask resets to ones in implemented positions
// - mask survives warm reset; takes effect after reset or link stop
// - secondary mask bits allow peer traffic and primary reachability
// - default port picks compat target or upstream destination
// - default port holds through warm reset, effective after event
// - decode off sends non-config requests to default port, abort if outside partition
// - decode on routes normally; never to compat port outside partition
// - cold reset select with bus reset cold-resets partition ports
// - cold reset select writable here; writes ignored while bus reset asserted
// - counter index selects counter; reserved reads 0; resets 0
// - range index selects range word; unimplemented base reads ones, limit 0; resets 0
// - hotswap status bit reads live pin level on secondary only, 0 on primary
// - hide bit on primary aborts configuration from internal bus
// - counter read returns then clears; counters saturate; test writes
// - counter index map: rx cmd, rx dword, tx cmd, tx dword
// - command counters count packets, dword counters add dwords
// - 64-bit base/limit, 16 MB grain, bit0 enable, limit low ones
// - index low bits pick word, high bits pick pair; absent pairs fixed
// - abort flag set by posted abort, cleared by writing one
`timescale 1ns/100ps
module switch_port_config_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic warm_rst,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_from_fabric,
  output logic [31:0] cfg_rdata,
  output logic cfg_master_abort,
  input wire logic posted_abort,
  input wire logic sec_bus_reset,
  input wire logic link_stop_event,
  input wire logic hotswap_pin,
  input wire logic [2:0] rx_cmd,
  input wire logic [2:0] tx_cmd,
  input wire logic [4:0] rx_dwords,
  input wire logic [4:0] tx_dwords,
  input wire logic req_valid,
  input wire logic req_is_cfg,
  input wire logic req_compat,
  input wire logic [63:0] req_addr,
  input wire logic [4:0] req_target,
  output logic [4:0] req_dest,
  output logic req_abort,
  output logic req_in_range,
  output logic [31:0] active_mask,
  output logic [4:0] active_default_port,
  output logic nonfatal_irq,
  output logic cold_reset_out,
  output logic power_good_n
);
  import swcfg_pkg::*;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_hold = 3'b010,
    st_release = 3'b100
  } cold_e;

  cold_e state, next_state;
  logic [31:0] part_mask;
  logic [4:0] default_port;
  logic decode_en, cold_select, hide;
  logic [3:0] ctr_index;
  logic [5:0] range_index;
  logic abort_flag, flood_en, fatal_en, nonfatal_en;
  logic [31:0] ctr [0:num_ctrs-1];
  logic [31:0] range_rdata;
  logic [31:0] base_lo [0:num_pairs-1];
  logic [31:0] base_hi [0:num_pairs-1];
  logic [31:0] lim_lo [0:num_pairs-1];
  logic [31:0] lim_hi [0:num_pairs-1];
  logic bus_reset_q;

  // decode of the access
  wire access_blocked = hide && is_primary && cfg_from_fabric;
  wire wr_ok = cfg_wr && !access_blocked;
  wire rd_ok = cfg_rd && !access_blocked;
  wire wr_cmd = wr_ok && cfg_addr == off_cmd;
  wire wr_mask = wr_ok && cfg_addr == off_mask;
  wire wr_info = wr_ok && cfg_addr == off_info;
  wire wr_ctr = wr_ok && cfg_addr == off_ctr;
  wire wr_range = wr_ok && cfg_addr == off_range;
  wire rd_ctr = rd_ok && cfg_addr == off_ctr;
  wire ctr_valid = ctr_index < 4'(num_ctrs);
  wire cold_start = sec_bus_reset && !bus_reset_q && cold_select;
  wire apply_event = link_stop_event || state == st_release;
  wire any_reset = warm_rst || cold_start;

  // implemented port positions, own port forced on, absent forced off
  wire [31:0] mask_fixed = (part_mask & mask_reset)
      | (32'h1 << own_port);

  wire [31:0] cmd_word = {cap_type, nonfatal_en, fatal_en, flood_en,
      abort_flag, 7'h00, 16'h0000};
  wire [31:0] info_word = {8'h00, hide & is_primary,
      hotswap_pin & ~is_primary, range_index, 4'h0, ctr_index, 1'b0,
      cold_select, decode_en & is_primary, default_port};
  wire [31:0] ctr_word = ctr_valid ? ctr[ctr_index] : 32'h0;

  logic [31:0] rd_mux;
  always_comb begin
    case (cfg_addr)
      off_cmd: rd_mux = {cmd_word[31:16], cap_next, cap_id};
      off_mask: rd_mux = mask_fixed;
      off_info: rd_mux = info_word;
      off_ctr: rd_mux = ctr_word;
      off_range: rd_mux = range_rdata;
      default: rd_mux = 32'h0;
    endcase
  end

  range_store u_ranges (
    .clk(clk),
    .rst(rst),
    .addr(range_index),
    .wr(wr_range),
    .wdata(cfg_wdata),
    .rdata(range_rdata)
  );

  // shadow copies of range words for decode; same masking
  wire [3:0] pair_sel = range_index[5:2];
  genvar p;
  generate
    for (p = 0; p < num_pairs; p++) begin : g_pair
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          base_lo[p] <= 32'h0;
          base_hi[p] <= 32'h0;
          lim_lo[p] <= 32'h0;
          lim_hi[p] <= 32'h0;
        end else if (wr_range && pair_sel == 4'(p)) begin
          case (range_index[1:0])
            2'h0: base_lo[p] <= cfg_wdata & (range_keep_mask | 32'h1);
            2'h1: base_hi[p] <= cfg_wdata;
            2'h2: lim_lo[p] <= cfg_wdata & range_keep_mask;
            default: lim_hi[p] <= cfg_wdata;
          endcase
        end
      end
    end
  endgenerate

  // range hit: limit low bits treated as ones, base above limit misses
  logic hit;
  always_comb begin
    hit = 1'b0;
    for (int k = 0; k < num_pairs; k++) begin
      if (base_lo[k][0]
          && req_addr >= {base_hi[k], base_lo[k][31:24], 24'h0}
          && req_addr <= {lim_hi[k], lim_lo[k][31:24], 24'hffffff}) begin
        hit = 1'b1;
      end
    end
  end

  // routing decision
  // routing sees only the loaded mask, never a freshly written one
  wire dest_ok = active_mask[req_target];
  wire def_ok = active_mask[active_default_port];
  logic [4:0] next_dest;
  logic next_abort;
  always_comb begin
    next_dest = req_target;
    next_abort = 1'b0;
    if (is_primary && !decode_en && !req_is_cfg) begin
      next_dest = active_default_port;
      next_abort = !def_ok;
    end else if (req_compat && is_primary) begin
      next_dest = active_default_port;
      next_abort = !def_ok;
    end else begin
      next_abort = !dest_ok;
    end
  end

  // cold reset sequencing of partition ports
  always_comb begin
    case (state)
      st_idle: next_state = cold_start ? st_hold : st_idle;
      st_hold: next_state = sec_bus_reset ? st_hold : st_release;
      st_release: next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      bus_reset_q <= 1'b0;
      cold_reset_out <= 1'b0;
      power_good_n <= 1'b0;
    end else begin
      state <= next_state;
      bus_reset_q <= sec_bus_reset;
      cold_reset_out <= next_state != st_idle;
      power_good_n <= next_state == st_hold;
    end
  end

  // cold-reset-only fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      part_mask <= mask_reset;
      default_port <= default_port_reset;
      hide <= 1'b0;
      abort_flag <= 1'b0;
    end else begin
      if (wr_mask) begin
        part_mask <= cfg_wdata & mask_reset;
      end
      if (wr_info) begin
        default_port <= cfg_wdata[4:0];
        hide <= cfg_wdata[info_hide_bit] & is_primary;
      end
      if (posted_abort) begin
        abort_flag <= 1'b1;
      end else if (wr_cmd && cfg_wdata[16 + cmd_abort_bit]) begin
        abort_flag <= 1'b0;
      end
    end
  end

  // warm-reset fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      decode_en <= 1'b0;
      cold_select <= 1'b0;
      ctr_index <= ctr_index_reset;
      range_index <= range_index_reset;
      flood_en <= 1'b0;
      fatal_en <= 1'b0;
      nonfatal_en <= 1'b0;
    end else if (warm_rst) begin
      decode_en <= 1'b0;
      cold_select <= 1'b0;
      ctr_index <= ctr_index_reset;
      range_index <= range_index_reset;
      flood_en <= 1'b0;
      fatal_en <= 1'b0;
      nonfatal_en <= 1'b0;
    end else begin
      if (wr_info) begin
        decode_en <= cfg_wdata[info_decode_bit] & is_primary;
        if (!sec_bus_reset) begin
          cold_select <= cfg_wdata[info_cold_bit];
        end
        ctr_index <= cfg_wdata[11:8];
        range_index <= cfg_wdata[21:16];
      end
      if (wr_cmd) begin
        flood_en <= cfg_wdata[16 + cmd_flood_bit];
        fatal_en <= cfg_wdata[16 + cmd_fatal_bit];
        nonfatal_en <= cfg_wdata[16 + cmd_nonfatal_bit];
      end
    end
  end

  // performance counters: index 0-2 rx cmd, 3-5 rx dw, 6-8 tx cmd, 9-b tx dw
  genvar c;
  generate
    for (c = 0; c < num_ctrs; c++) begin : g_ctr
      localparam int ch = c % 3;
      localparam bit is_dw = (c / 3) % 2 == 1;
      localparam bit is_tx = c >= 6;
      wire ev = is_tx ? tx_cmd[ch] : rx_cmd[ch];
      wire [31:0] inc = !ev ? 32'h0 : !is_dw ? 32'h1 :
          {27'h0, is_tx ? tx_dwords : rx_dwords};
      wire [32:0] sum = {1'b0, ctr[c]} + {1'b0, inc};
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ctr[c] <= 32'h0;
        end else if (warm_rst) begin
          ctr[c] <= 32'h0;
        end else if (wr_ctr && ctr_index == 4'(c)) begin
          ctr[c] <= cfg_wdata;
        end else if (rd_ctr && ctr_index == 4'(c)) begin
          ctr[c] <= inc;
        end else begin
          ctr[c] <= sum[32] ? ctr_full : sum[31:0];
        end
      end
    end
  endgenerate

  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 32'h0;
      cfg_master_abort <= 1'b0;
      active_mask <= mask_reset | (32'h1 << own_port);
      active_default_port <= default_port_reset;
      req_dest <= 5'h0;
      req_abort <= 1'b0;
      req_in_range <= 1'b0;
      nonfatal_irq <= 1'b0;
    end else begin
      cfg_rdata <= rd_ok ? rd_mux : 32'h0;
      cfg_master_abort <= (cfg_rd || cfg_wr) && access_blocked;
      if (any_reset || apply_event) begin
        active_mask <= mask_fixed;
        active_default_port <= default_port;
      end
      req_dest <= req_valid ? next_dest : 5'h0;
      req_abort <= req_valid && next_abort;
      req_in_range <= req_valid && decode_en && hit;
      nonfatal_irq <= abort_flag && nonfatal_en;
    end
  end
endmodule

/* File: test/switch_port_config_regs_properties.sv */
// assertion checker for the switch port configuration registers
`timescale 1ns/100ps
module switch_port_config_regs_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic warm_rst,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic cfg_from_fabric,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_master_abort,
  input wire logic posted_abort,
  input wire logic sec_bus_reset,
  input wire logic link_stop_event,
  input wire logic req_valid,
  input wire logic req_abort,
  input wire logic [31:0] active_mask,
  input wire logic nonfatal_irq,
  input wire logic cold_reset_out,
  input wire logic power_good_n
);
  import swcfg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_loc = cfg_rd && !cfg_from_fabric;
  a_cap_type: assert property (
    rd_loc && cfg_addr == off_cmd |=> cfg_rdata[31:27] == cap_type
    && cfg_rdata[15:0] == {cap_next, cap_id})
    else $error("capability word wrong");
  a_info_reserved: assert property (
    rd_loc && cfg_addr == off_info |=> (cfg_rdata & 32'hff40_f080) == 0)
    else $error("reserved info bits not zero");
  a_mask_fixed: assert property (
    active_mask[own_port] && (active_mask & ~mask_reset) == 32'h0)
    else $error("hardwired mask bits wrong");
  a_mask_hold: assert property (
    !$stable(active_mask) |-> $past(link_stop_event) || $past(cold_reset_out)
    || $past(warm_rst) || $past(sec_bus_reset))
    else $error("active mask changed without event");
  a_hide_source: assert property (
    cfg_master_abort |-> $past(cfg_from_fabric && (cfg_rd || cfg_wr)))
    else $error("master abort without fabric access");
  a_irq_rise: assert property (
    $rose(nonfatal_irq) |-> $past(posted_abort) || $past(posted_abort, 2)
    || $past(cfg_wr) || $past(cfg_wr, 2))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property (
    $fell(nonfatal_irq) |-> $past(cfg_wr) || $past(cfg_wr, 2)
    || $past(warm_rst) || $past(warm_rst, 2))
    else $error("interrupt fell without clear");
  a_cold_cause: assert property (
    power_good_n |-> cold_reset_out
    && ($past(sec_bus_reset) || $past(sec_bus_reset, 2)))
    else $error("power good dropped without bus reset");
  a_route_source: assert property (
    req_abort |-> $past(req_valid))
    else $error("route abort without query");
  a_cold_release: assert property (
    cold_reset_out && !power_good_n |=> !cold_reset_out)
    else $error("cold reset release longer than one cycle");
endmodule
bind switch_port_config_regs switch_port_config_regs_properties u_props (
  .clk, .rst, .warm_rst, .cfg_addr, .cfg_rd, .cfg_wr, .cfg_from_fabric,
  .cfg_rdata, .cfg_master_abort, .posted_abort, .sec_bus_reset,
  .link_stop_event, .req_valid, .req_abort, .active_mask, .nonfatal_irq,
  .cold_reset_out, .power_good_n);

/* File: test/test_switch_port_config_regs.sv */
// self-checking bench for the switch port configuration registers
`timescale 1ns/100ps
`define chk(a, b) \
  begin \
    checks_done++; \
    if ((a) !== (b)) begin \
      miscompares++; \
      $display("unexpected at %0t: got %h want %h", $time, a, b); \
    end \
  end
module test_switch_port_config_regs;
  import swcfg_pkg::*;
  localparam logic [31:0] cmd_base = {cap_type, 11'h0, cap_next, cap_id};
  logic clk, rst = 1'b1, warm_rst = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0;
  logic cfg_from_fabric = 1'b0, posted_abort = 1'b0, sec_bus_reset = 1'b0;
  logic link_stop_event = 1'b0, hotswap_pin = 1'b1, req_valid = 1'b0;
  logic req_is_cfg = 1'b0, req_compat = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic [2:0] rx_cmd = 3'h0, tx_cmd = 3'h0;
  logic [4:0] rx_dwords = 5'h00, tx_dwords = 5'h00, req_target = 5'h00;
  logic [63:0] req_addr = 64'h0;
  logic [31:0] cfg_rdata, active_mask, d, w, m;
  logic [4:0] req_dest, active_default_port, dw, tw;
  logic cfg_master_abort, req_abort, req_in_range, nonfatal_irq, ab;
  logic cold_reset_out, power_good_n;
  logic [31:0] expc [16];
  int miscompares, checks_done, c, k;
  switch_port_config_regs dut (.clk, .rst, .warm_rst, .cfg_addr, .cfg_rd,
    .cfg_wr, .cfg_wdata, .cfg_from_fabric, .cfg_rdata, .cfg_master_abort,
    .posted_abort, .sec_bus_reset, .link_stop_event, .hotswap_pin, .rx_cmd,
    .tx_cmd, .rx_dwords, .tx_dwords, .req_valid, .req_is_cfg, .req_compat,
    .req_addr, .req_target, .req_dest, .req_abort, .req_in_range,
    .active_mask, .active_default_port, .nonfatal_irq, .cold_reset_out,
    .power_good_n);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] mask_exp(input logic [31:0] v);
    return (v & mask_reset) | 32'h1;
  endfunction
  function automatic logic [31:0] range_exp(input logic [1:0] i,
                                            input logic [31:0] v);
    if (i == 2'h0) return v & 32'hff00_0001;
    if (i == 2'h2) return v & range_keep_mask;
    return v;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    cfg_addr <= a;
    cfg_wdata <= v;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata;
    ab = cfg_master_abort;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `chk(d, e)
  endtask
  task automatic rq(input logic [4:0] ed, input logic ea);
    req_valid <= 1'b1;
    req_addr <= {$urandom, $urandom};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    `chk(req_dest, ed)
    `chk(req_abort, ea)
    @(posedge clk);
  endtask
  task automatic rh(input logic [63:0] a, input logic e);
    req_valid <= 1'b1;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    `chk(req_in_range, e)
    @(posedge clk);
  endtask
  task automatic pa;
    posted_abort <= 1'b1;
    @(posedge clk);
    posted_abort <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    complete_run();
  end
  initial begin
    void'($urandom(73415));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(off_cmd, cmd_base);
    rc(off_mask, mask_reset);
    rc(off_info, {27'h0, default_port_reset});
    rq(default_port_reset, 1'b0);
    m = $urandom & 32'hffff_fffd;
    wr(off_mask, m);
    rc(off_mask, mask_exp(m));
    `chk(active_mask, mask_reset)
    rq(default_port_reset, 1'b0);
    link_stop_event <= 1'b1;
    @(posedge clk);
    link_stop_event <= 1'b0;
    @(posedge clk);
    `chk(active_mask, mask_exp(m))
    `chk(active_default_port, default_port_reset)
    rq(default_port_reset, 1'b1);
    w = $urandom & 32'hff7f_ffff;
    wr(off_info, w);
    rc(off_info, w & 32'h003f_0f7f);
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    @(posedge clk);
    rc(off_info, w & 32'h1f);
    rc(off_mask, mask_exp(m));
    wr(off_cmd, 32'h0400_0000);
    pa();
    `chk(nonfatal_irq, 1'b1)
    rc(off_cmd, cmd_base | 32'h0480_0000);
    wr(off_cmd, 32'h0480_0000);
    repeat (2) @(posedge clk);
    `chk(nonfatal_irq, 1'b0)
    wr(off_cmd, 32'h0);
    pa();
    `chk(nonfatal_irq, 1'b0)
    foreach (expc[i]) expc[i] = 32'h0;
    repeat (60) begin
      c = $urandom % 3;
      k = $urandom % 3;
      dw = 5'($urandom);
      tw = 5'($urandom);
      rx_cmd <= 3'h1 << c;
      rx_dwords <= dw;
      tx_cmd <= 3'h1 << k;
      tx_dwords <= tw;
      expc[c] += 1;
      expc[3 + c] += 32'(dw);
      expc[6 + k] += 1;
      expc[9 + k] += 32'(tw);
      @(posedge clk);
    end
    rx_cmd <= 3'h0;
    tx_cmd <= 3'h0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      wr(off_info, 32'(i) << 8);
      rc(off_ctr, i < num_ctrs ? expc[i] : 32'h0);
      rc(off_ctr, 32'h0);
    end
    wr(off_info, 32'h0);
    wr(off_ctr, 32'hffff_fffe);
    rx_cmd <= 3'h1;
    repeat (2) @(posedge clk);
    rx_cmd <= 3'h0;
    rc(off_ctr, ctr_full);
    for (int i = 0; i < 16; i++) begin
      w = $urandom;
      wr(off_info, 32'(i) << 16);
      wr(off_range, w);
      rc(off_range, range_exp(2'(i), w));
      w = i == 0 ? 32'h0100_0001 : i == 2 ? 32'h0100_0000 : 32'h0;
      wr(off_range, w);
    end
    wr(off_info, 32'h0010_0000);
    rc(off_range, 32'hffff_ffff);
    wr(off_info, 32'h0013_0000);
    rc(off_range, 32'h0);
    link_stop_event <= 1'b1;
    @(posedge clk);
    link_stop_event <= 1'b0;
    req_target <= 5'h01;
    req_is_cfg <= 1'b1;
    rq(5'h01, 1'b1);
    req_is_cfg <= 1'b0;
    rq(5'h00, 1'b0);
    rh({32'h0, 8'h01, 24'($urandom)}, 1'b0);
    wr(off_info, 32'h0000_0020);
    rh({32'h0, 8'h01, 24'($urandom)}, 1'b1);
    rh({32'h0, 8'h02, 24'($urandom)}, 1'b0);
    rh({$urandom | 32'h1, 8'h01, 24'($urandom)}, 1'b0);
    rq(5'h01, 1'b1);
    req_compat <= 1'b1;
    rq(5'h00, 1'b0);
    req_compat <= 1'b0;
    wr(off_info, 32'h0080_0000);
    cfg_from_fabric <= 1'b1;
    wr(off_info, 32'h0);
    rd(off_info);
    `chk(ab, 1'b1)
    cfg_from_fabric <= 1'b0;
    rc(off_info, 32'h0080_0000);
    wr(off_info, 32'h0000_0040);
    sec_bus_reset <= 1'b1;
    repeat (3) @(posedge clk);
    `chk(power_good_n, 1'b1)
    `chk(cold_reset_out, 1'b1)
    sec_bus_reset <= 1'b0;
    @(posedge clk);
    #1;
    `chk(power_good_n, 1'b0)
    `chk(cold_reset_out, 1'b1)
    repeat (3) @(posedge clk);
    `chk(cold_reset_out, 1'b0)
    complete_run();
  end
endmodule
